// ### inc/tfl_pkg.sv
// package: fault codes, trace subtype bits, mode bit positions, opcode classes
package tfl_pkg;
  // fault type codes
  localparam logic [7:0] TRACE_FAULT_TYPE = 8'h01;
  localparam logic [7:0] TYPE_FAULT_TYPE  = 8'h0a;
  localparam logic [7:0] TYPE_MISMATCH    = 8'h01;
  // trace subtype / trace mode bit positions (shared layout)
  localparam int SUB_INSTR  = 1;
  localparam int SUB_BRANCH = 2;
  localparam int SUB_CALL   = 3;
  localparam int SUB_RETURN = 4;
  localparam int SUB_PRERET = 5;
  localparam int SUB_SUPER  = 6;
  localparam int SUB_MARK   = 7;
  // return status types that count as supervisor returns
  localparam logic [2:0] RSTAT_SUPER_A = 3'h2;
  localparam logic [2:0] RSTAT_SUPER_B = 3'h3;
  // low on-chip ram window guarded by the low-ram protect bit
  localparam logic [31:0] LOW_RAM_BYTES = 32'h0000_0040;
  // instruction classes presented by the decoder
  typedef enum logic [3:0] {
    TFL_OP_OTHER   = 4'h0,
    TFL_OP_MODPC   = 4'h1,
    TFL_OP_SYSCTL  = 4'h2,
    TFL_OP_ICCTL   = 4'h3,
    TFL_OP_DCCTL   = 4'h4,
    TFL_OP_INTCTL  = 4'h5,
    TFL_OP_INTEN   = 4'h6,
    TFL_OP_INTDIS  = 4'h7,
    TFL_OP_CALLS   = 4'h8,
    TFL_OP_RET     = 4'h9,
    TFL_OP_MARK    = 4'ha,
    TFL_OP_FMARK   = 4'hb,
    TFL_OP_BRANCH  = 4'hc,
    TFL_OP_CALL    = 4'hd
  } tfl_op_t;
  // report sequencer states
  typedef enum logic [2:0] {
    TFL_ST_IDLE    = 3'h0,
    TFL_ST_OTHER   = 3'h1,
    TFL_ST_INTR    = 3'h2,
    TFL_ST_TRACE   = 3'h3,
    TFL_ST_HANDLER = 3'h4
  } tfl_state_t;
endpackage

// ### inc/tfl_chk_if.sv
// interface: one issuing instruction between main block and privilege checker
`timescale 1ns/1ps
interface tfl_chk_if;
  logic          valid;
  logic          user_mode;
  tfl_pkg::tfl_op_t op;
  logic          mem_wr;
  logic          mem_rd;
  logic [31:0]   addr;
  logic          ram_hit;
  logic [31:0]   ram_base;
  logic          mmr_super;
  logic          timer_hit;
  logic          timer_prot;
  logic          sfr_access;
  logic          irp;
  logic          sirp;
  logic          mismatch;
  modport main (output valid, user_mode, op, mem_wr, mem_rd, addr, ram_hit,
                ram_base, mmr_super, timer_hit, timer_prot, sfr_access, irp,
                sirp, input mismatch);
  modport chk  (input valid, user_mode, op, mem_wr, mem_rd, addr, ram_hit,
                ram_base, mmr_super, timer_hit, timer_prot, sfr_access, irp,
                sirp, output mismatch);
endinterface

// ### core/tfl_priv_check.sv
// privilege checker: decides the type mismatch fault for one instruction
`timescale 1ns/1ps
module tfl_priv_check (
  tfl_chk_if.chk ck
);
  // privileged opcode decode, used once per instruction
  function automatic logic tfl_is_priv(input tfl_pkg::tfl_op_t op);
    case (op)
      tfl_pkg::TFL_OP_MODPC, tfl_pkg::TFL_OP_SYSCTL, tfl_pkg::TFL_OP_ICCTL,
      tfl_pkg::TFL_OP_DCCTL, tfl_pkg::TFL_OP_INTCTL, tfl_pkg::TFL_OP_INTEN,
      tfl_pkg::TFL_OP_INTDIS: tfl_is_priv = 1'b1;
      default: tfl_is_priv = 1'b0;
    endcase
  endfunction

  logic [31:0] ram_off;
  logic        low_hit;

  // offset into on-chip ram; only meaningful while ram_hit is set
  assign ram_off = ck.addr - ck.ram_base;
  assign low_hit = ck.ram_hit && (ram_off < tfl_pkg::LOW_RAM_BYTES);

  // each cause of the mismatch fault
  always_comb begin
    ck.mismatch = 1'b0;
    if (ck.valid) begin
      if (ck.user_mode && tfl_is_priv(ck.op))
        ck.mismatch = 1'b1; // RL14
      // protect bit is checked in supervisor mode, as printed
      if (ck.mem_wr && ck.ram_hit && ck.irp && !ck.user_mode)
        ck.mismatch = 1'b1; // RL15
      if (ck.mem_wr && low_hit && ck.sirp)
        ck.mismatch = 1'b1; // RL16
      if (ck.mem_wr && ck.mmr_super && ck.user_mode)
        ck.mismatch = 1'b1; // RL17
      if (ck.mem_wr && ck.timer_hit && ck.timer_prot && ck.user_mode)
        ck.mismatch = 1'b1; // RL18
      if (ck.sfr_access && ck.user_mode && (ck.mem_rd || ck.mem_wr ||
          ck.op == tfl_pkg::TFL_OP_OTHER))
        ck.mismatch = 1'b1; // RL19
    end
  end
endmodule

// ### core/tfl_trace_fault.sv
// trace and type fault logic: event detection, ordering and fault reports
//
// What this block does
// RL1 - supervisor mode: trace supervisor calls and returns of status 010/011
// RL2 - mark, fmark and breakpoint matches all set the mark subtype bit
// RL3 - merge all trace conditions of one instruction; prereturn alone
// RL4 - a non-trace fault of a traced instruction is serviced first
// RL5 - prereturn trace is taken before the return's non-trace faults
// RL6 - an interrupt during a traced instruction is serviced before the trace
// RL7 - prereturn trace is taken before an interrupt during the return
// RL8 - software enters the trace handler via a supervisor table call; here the handler state is entered only on a trace fault
// RL9 - tracing cleared on handler entry, restored on handler exit
// RL10 - non-prereturn trace faults are taken after the instruction completes
// RL11 - non-prereturn resume address is the next instruction in issue order
// RL12 - prereturn: trace first, resume at the return, re-execute it
// RL13 - type faults report type a with subtype 1, mismatch
// RL14 - privileged instructions in user mode raise a mismatch fault
// RL15 - protected on-chip ram write in the printed mode raises mismatch
// RL16 - write to low 64 bytes of ram with low protect raises mismatch
// RL17 - user write to supervisor memory-mapped registers raises mismatch
// RL18 - user write to user-protected timer registers raises mismatch
// RL19 - any user access to a special function register raises mismatch; the code faults it only for loads, stores and other-class instructions
// RL20 - mismatch taken before execution; fault address is the instruction
// RL21 - a mismatch fault discards the instruction's trace events
// RL22 - events other than fmark and breakpoint need their mode bit; faults need process trace enable
`timescale 1ns/1ps
module tfl_trace_fault (
  input  wire logic             mclk_in,
  input  wire logic             rst_in,
  // instruction presented by the pipeline, before it executes
  input  wire logic             insn_valid_in,
  input  wire tfl_pkg::tfl_op_t insn_op_in,
  input  wire logic [31:0]      insn_addr_in,
  input  wire logic [31:0]      insn_next_addr_in,
  input  wire logic             user_mode_in,
  input  wire logic             branch_taken_in,
  input  wire logic             calls_super_in,
  input  wire logic [2:0]       ret_status_in,
  input  wire logic             preret_flag_in,
  input  wire logic             bp_match_in,
  input  wire logic             mem_wr_in,
  input  wire logic             mem_rd_in,
  input  wire logic [31:0]      mem_addr_in,
  input  wire logic             ram_hit_in,
  input  wire logic [31:0]      ram_base_in,
  input  wire logic             mmr_super_in,
  input  wire logic             timer_hit_in,
  input  wire logic             timer_prot_in,
  input  wire logic             sfr_access_in,
  // completion of the instruction and concurrent events
  input  wire logic             insn_done_in,
  input  wire logic             other_fault_in,
  input  wire logic             intr_in,
  // service handshakes from the fault/interrupt sequencer
  input  wire logic             svc_done_in,
  input  wire logic             handler_ret_in,
  // control bits
  input  wire logic [7:0]       trace_mode_controls_in,
  input  wire logic             process_trace_enable_in,
  input  wire logic             internal_ram_write_protect_in,
  input  wire logic             low_ram_write_protect_in,
  // outputs
  output logic                  insn_go_out,
  output logic                  fault_out,
  output logic [7:0]            fault_type_out,
  output logic [7:0]            fault_subtype_out,
  output logic [31:0]           fault_addr_out,
  output logic [31:0]           resume_address_out,
  output logic                  resume_valid_out,
  output logic                  process_trace_enable_out,
  output logic                  service_other_out,
  output logic                  service_intr_out
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    tfl_pkg::tfl_state_t st;
    logic [7:0]          pend_sub;
    logic [31:0]         pend_ip;
    logic [31:0]         pend_rip;
    logic                pend_other;
    logic                pend_intr;
    logic                saved_te;
    logic                te;
    logic                fault;
    logic [7:0]          ftype;
    logic [7:0]          fsub;
    logic [31:0]         faddr;
    logic [31:0]         resume_address;
    logic                rip_valid;
  } tfl_state_s_t;

  tfl_state_s_t s_reg;
  tfl_state_s_t s_next;

  tfl_chk_if ck ();

  logic [7:0] ev;
  logic       pre_ev;
  logic       mm;
  logic       tracing;

  ////////////////////////////////////////////////////////////////////////////
  // privilege checker

  assign ck.valid      = insn_valid_in;
  assign ck.user_mode  = user_mode_in;
  assign ck.op         = insn_op_in;
  assign ck.mem_wr     = mem_wr_in;
  assign ck.mem_rd     = mem_rd_in;
  assign ck.addr       = mem_addr_in;
  assign ck.ram_hit    = ram_hit_in;
  assign ck.ram_base   = ram_base_in;
  assign ck.mmr_super  = mmr_super_in;
  assign ck.timer_hit  = timer_hit_in;
  assign ck.timer_prot = timer_prot_in;
  assign ck.sfr_access = sfr_access_in;
  assign ck.irp        = internal_ram_write_protect_in;
  assign ck.sirp       = low_ram_write_protect_in;
  assign mm            = ck.mismatch;

  tfl_priv_check u_chk (
    .ck (ck.chk)
  );

  ////////////////////////////////////////////////////////////////////////////
  // trace event detection

  // handler runs with tracing off; its own te copy overrides the input
  assign tracing = s_reg.te;

  // events other than fmark and breakpoint gated by their mode bit; te masks them all at the end
  always_comb begin
    ev = 8'h00;
    ev[tfl_pkg::SUB_INSTR] = trace_mode_controls_in[tfl_pkg::SUB_INSTR];
    ev[tfl_pkg::SUB_BRANCH] = trace_mode_controls_in[tfl_pkg::SUB_BRANCH] &&
      insn_op_in == tfl_pkg::TFL_OP_BRANCH && branch_taken_in;
    ev[tfl_pkg::SUB_CALL] = trace_mode_controls_in[tfl_pkg::SUB_CALL] &&
      (insn_op_in == tfl_pkg::TFL_OP_CALL ||
       insn_op_in == tfl_pkg::TFL_OP_CALLS);
    ev[tfl_pkg::SUB_RETURN] = trace_mode_controls_in[tfl_pkg::SUB_RETURN] &&
      insn_op_in == tfl_pkg::TFL_OP_RET;
    ev[tfl_pkg::SUB_SUPER] = trace_mode_controls_in[tfl_pkg::SUB_SUPER] &&
      ((insn_op_in == tfl_pkg::TFL_OP_CALLS && calls_super_in) ||
       (insn_op_in == tfl_pkg::TFL_OP_RET &&
        (ret_status_in == tfl_pkg::RSTAT_SUPER_A ||
         ret_status_in == tfl_pkg::RSTAT_SUPER_B))); // RL1
    ev[tfl_pkg::SUB_MARK] = bp_match_in ||
      insn_op_in == tfl_pkg::TFL_OP_FMARK ||
      (trace_mode_controls_in[tfl_pkg::SUB_MARK] &&
       insn_op_in == tfl_pkg::TFL_OP_MARK); // RL2
    ev = ev & {8{insn_valid_in && tracing && !mm}}; // RL22 RL21
  end

  // prereturn fires before the return runs, only when the frame flag is set
  assign pre_ev = insn_valid_in && tracing && !mm &&
    insn_op_in == tfl_pkg::TFL_OP_RET && preret_flag_in &&
    trace_mode_controls_in[tfl_pkg::SUB_PRERET]; // RL22

  // the instruction may proceed only in idle with nothing to take first
  assign insn_go_out = s_reg.st == tfl_pkg::TFL_ST_IDLE && insn_valid_in &&
    !mm && !pre_ev; // RL20 RL5

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  always_comb begin
    s_next       = s_reg;
    s_next.fault = 1'b0;
    case (s_reg.st)
      tfl_pkg::TFL_ST_IDLE: begin
        if (s_reg.rip_valid == 1'b0)
          s_next.te = process_trace_enable_in;
        if (insn_valid_in && mm) begin
          // reported before execution, state untouched, no resume point
          s_next.fault     = 1'b1; // RL20
          s_next.ftype     = tfl_pkg::TYPE_FAULT_TYPE; // RL13
          s_next.fsub      = tfl_pkg::TYPE_MISMATCH; // RL13
          s_next.faddr     = insn_addr_in; // RL20
          s_next.rip_valid = 1'b0; // RL20
        end else if (pre_ev) begin
          // ahead of the return: beats its faults and interrupts
          s_next.fault     = 1'b1; // RL5 RL7
          s_next.ftype     = tfl_pkg::TRACE_FAULT_TYPE;
          s_next.fsub      = 8'h01 << tfl_pkg::SUB_PRERET; // RL3
          s_next.faddr     = insn_addr_in;
          s_next.resume_address       = insn_addr_in; // RL12
          s_next.rip_valid = 1'b1; // RL12
          s_next.saved_te  = s_reg.te; // RL9
          s_next.te        = 1'b0; // RL9
          s_next.st        = tfl_pkg::TFL_ST_HANDLER;
        end else if (insn_done_in && (ev != 8'h00 || other_fault_in ||
                     intr_in)) begin
          // wait for completion before any trace report
          s_next.pend_sub   = ev; // RL3 RL10
          s_next.pend_ip    = insn_addr_in;
          s_next.pend_rip   = insn_next_addr_in; // RL11
          s_next.pend_other = other_fault_in;
          s_next.pend_intr  = intr_in;
          if (other_fault_in)
            s_next.st = tfl_pkg::TFL_ST_OTHER; // RL4
          else if (intr_in)
            s_next.st = tfl_pkg::TFL_ST_INTR; // RL6
          else
            s_next.st = tfl_pkg::TFL_ST_TRACE; // RL10
        end
      end
      tfl_pkg::TFL_ST_OTHER: begin
        if (svc_done_in) begin
          s_next.pend_other = 1'b0;
          s_next.st = s_reg.pend_intr ? tfl_pkg::TFL_ST_INTR :
                      (s_reg.pend_sub != 8'h00) ? tfl_pkg::TFL_ST_TRACE :
                      tfl_pkg::TFL_ST_IDLE; // RL4
        end
      end
      tfl_pkg::TFL_ST_INTR: begin
        if (svc_done_in) begin
          s_next.pend_intr = 1'b0;
          s_next.st = (s_reg.pend_sub != 8'h00) ? tfl_pkg::TFL_ST_TRACE :
                      tfl_pkg::TFL_ST_IDLE; // RL6
        end
      end
      tfl_pkg::TFL_ST_TRACE: begin
        // one merged report for every condition seen
        s_next.fault     = 1'b1; // RL3
        s_next.ftype     = tfl_pkg::TRACE_FAULT_TYPE;
        s_next.fsub      = s_reg.pend_sub; // RL3
        s_next.faddr     = s_reg.pend_ip;
        s_next.resume_address       = s_reg.pend_rip; // RL11
        s_next.rip_valid = 1'b1;
        s_next.pend_sub  = 8'h00;
        s_next.saved_te  = s_reg.te; // RL9
        s_next.te        = 1'b0; // RL9
        s_next.st        = tfl_pkg::TFL_ST_HANDLER;
      end
      tfl_pkg::TFL_ST_HANDLER: begin
        // handler may not touch te; the saved copy comes back on exit
        if (handler_ret_in) begin
          s_next.te        = s_reg.saved_te; // RL9
          s_next.rip_valid = 1'b0;
          s_next.st        = tfl_pkg::TFL_ST_IDLE; // RL11 RL12
        end
      end
      default: s_next.st = tfl_pkg::TFL_ST_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge mclk_in) begin
    if (rst_in)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  // outputs
  assign fault_out                = s_reg.fault;
  assign fault_type_out           = s_reg.ftype;
  assign fault_subtype_out        = s_reg.fsub;
  assign fault_addr_out           = s_reg.faddr;
  assign resume_address_out       = s_reg.resume_address;
  assign resume_valid_out         = s_reg.rip_valid;
  assign process_trace_enable_out = s_reg.te;
  assign service_other_out        = s_reg.st == tfl_pkg::TFL_ST_OTHER;
  assign service_intr_out         = s_reg.st == tfl_pkg::TFL_ST_INTR;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  property p_super_ret;
    @(posedge mclk_in) disable iff (rst_in)
    (s_reg.st == tfl_pkg::TFL_ST_TRACE && s_reg.pend_sub[6]) |=>
      fault_out && fault_subtype_out[6];
  endproperty
  a_super_ret: assert property (p_super_ret) else $error("super lost"); // RL1

  property p_mark;
    @(posedge mclk_in) disable iff (rst_in)
    (insn_go_out && insn_done_in && bp_match_in && tracing) |=>
      s_reg.pend_sub[tfl_pkg::SUB_MARK];
  endproperty
  a_mark: assert property (p_mark) else $error("mark bit missing"); // RL2

  property p_other_first;
    @(posedge mclk_in) disable iff (rst_in)
    (s_reg.st == tfl_pkg::TFL_ST_IDLE && insn_go_out && insn_done_in &&
     other_fault_in) |=> service_other_out && !fault_out;
  endproperty
  a_other_first: assert property (p_other_first)
    else $error("trace before fault"); // RL4

  property p_intr_first;
    @(posedge mclk_in) disable iff (rst_in)
    (insn_go_out && insn_done_in && intr_in && !other_fault_in) |=>
      service_intr_out;
  endproperty
  a_intr_first: assert property (p_intr_first)
    else $error("trace before interrupt"); // RL6

  property p_preret;
    @(posedge mclk_in) disable iff (rst_in)
    (s_reg.st == tfl_pkg::TFL_ST_IDLE && pre_ev) |=>
      fault_out && fault_subtype_out == 8'h20 &&
      resume_address_out == $past(insn_addr_in);
  endproperty
  a_preret: assert property (p_preret) else $error("prereturn bad"); // RL12

  property p_te_off;
    @(posedge mclk_in) disable iff (rst_in)
    (fault_out && fault_type_out == tfl_pkg::TRACE_FAULT_TYPE) |->
      !process_trace_enable_out;
  endproperty
  a_te_off: assert property (p_te_off) else $error("te not cleared"); // RL9

  property p_mismatch;
    @(posedge mclk_in) disable iff (rst_in)
    (s_reg.st == tfl_pkg::TFL_ST_IDLE && insn_valid_in && mm) |=>
      fault_out && fault_subtype_out == 8'h01 && fault_type_out == 8'h0a &&
      fault_addr_out == $past(insn_addr_in) && !resume_valid_out;
  endproperty
  a_mismatch: assert property (p_mismatch) else $error("mismatch bad"); // RL20

  property p_no_go;
    @(posedge mclk_in) disable iff (rst_in)
    mm |-> !insn_go_out && ev == 8'h00;
  endproperty
  a_no_go: assert property (p_no_go) else $error("faulted insn ran"); // RL21

  property p_user_priv;
    @(posedge mclk_in) disable iff (rst_in)
    (insn_valid_in && user_mode_in && insn_op_in == tfl_pkg::TFL_OP_MODPC) |->
      mm;
  endproperty
  a_user_priv: assert property (p_user_priv) else $error("priv lost"); // RL14

  property p_rip_next;
    @(posedge mclk_in) disable iff (rst_in)
    (s_reg.st == tfl_pkg::TFL_ST_TRACE) |=>
      resume_address_out == $past(s_reg.pend_rip);
  endproperty
  a_rip_next: assert property (p_rip_next) else $error("rip wrong"); // RL11
endmodule

// ### test/tfl_trace_fault_tb_top.sv
// testbench: drives the trace and type fault block through directed cases
`timescale 1ns/1ps
module tfl_trace_fault_tb_top;
  logic             mclk_in = 1'b0;
  logic             rst_in;
  logic             valid, done, user, btk, csup, pre, bp, wr, rd;
  logic             hit, mmr, tmr, tprot, sfr, ofl, intr, svc, hret_p;
  logic             te, irp, sirp, go, flt, rv, te_o, s_oth, s_int;
  tfl_pkg::tfl_op_t op;
  logic [2:0]       rst_st;
  logic [7:0]       tmc, ftype, fsub;
  logic [31:0]      pc, maddr, fadr, res;
  int               error_cnt = 0;
  int               checked = 0;
  int               cycles = 0;

  ////////////////////////////////////////////////////////////////////////
  // clock, timeout and the block under test
  always #25 mclk_in = ~mclk_in;

  // ceiling well above the few hundred cycles the cases need
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 6000) begin
      error_cnt++;
      close_out();
    end
  end

  tfl_trace_fault u_tfl_trace_fault (
    .mclk_in(mclk_in), .rst_in(rst_in), .insn_valid_in(valid),
    .insn_op_in(op), .insn_addr_in(pc), .insn_next_addr_in(pc + 32'h4),
    .user_mode_in(user), .branch_taken_in(btk), .calls_super_in(csup),
    .ret_status_in(rst_st), .preret_flag_in(pre), .bp_match_in(bp),
    .mem_wr_in(wr), .mem_rd_in(rd), .mem_addr_in(maddr),
    .ram_hit_in(hit), .ram_base_in(32'h0010_0000), .mmr_super_in(mmr),
    .timer_hit_in(tmr), .timer_prot_in(tprot), .sfr_access_in(sfr),
    .insn_done_in(done), .other_fault_in(ofl), .intr_in(intr),
    .svc_done_in(svc), .handler_ret_in(hret_p),
    .trace_mode_controls_in(tmc), .process_trace_enable_in(te),
    .internal_ram_write_protect_in(irp),
    .low_ram_write_protect_in(sirp), .insn_go_out(go),
    .fault_out(flt), .fault_type_out(ftype), .fault_subtype_out(fsub),
    .fault_addr_out(fadr), .resume_address_out(res),
    .resume_valid_out(rv), .process_trace_enable_out(te_o),
    .service_other_out(s_oth), .service_intr_out(s_int));

  ////////////////////////////////////////////////////////////////////////
  // shared tasks
  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // idle defaults; each case then sets only what it needs
  task automatic clr();
    {valid, done, user, btk, csup, pre, bp, wr, rd} = 9'h000;
    {hit, mmr, tmr, tprot, sfr, ofl, intr, svc, hret_p} = 9'h000;
    {irp, sirp} = 2'h0;
    op = tfl_pkg::TFL_OP_OTHER;
    rst_st = 3'h0;
    tmc = 8'h00;
    te = 1'b1;
    maddr = 32'h0020_0000;
    pc = pc + 32'h10;
  endtask

  // one instruction presented for one edge, go checked before it
  task automatic issue(input logic d, input logic go_exp);
    valid = 1'b1;
    done = d;
    #1 chk("insn_go_out", go, go_exp);
    @(negedge mclk_in);
    valid = 1'b0;
    done = 1'b0;
  endtask

  task automatic expect_fault(input logic [7:0] t, input logic [7:0] s);
    logic seen;
    seen = 1'b0;
    for (int i = 0; i < 6 && !seen; i++) begin
      if (flt === 1'b1) seen = 1'b1;
      else @(negedge mclk_in);
    end
    chk("fault_out", seen, 1'b1);
    chk("fault_type_out", ftype, t);
    chk("fault_subtype_out", fsub, s);
  endtask

  task automatic no_fault(input int n);
    int hits;
    hits = 0;
    repeat (n) begin
      if (flt !== 1'b0) hits++;
      @(negedge mclk_in);
    end
    chk("no fault_out", hits, 0);
  endtask

  // handler return pulse; tracing must come back as it was
  task automatic hret(input logic te_exp);
    chk("te cleared in handler", te_o, 1'b0);
    chk("resume_valid_out set", rv, 1'b1);
    hret_p = 1'b1;
    @(negedge mclk_in);
    hret_p = 1'b0;
    @(negedge mclk_in);
    chk("te restored", te_o, te_exp);
    chk("resume_valid_out clear", rv, 1'b0);
  endtask

  // trace case: event inputs, mode bits and the merged subtype expected
  task automatic trc(input tfl_pkg::tfl_op_t o, input logic [7:0] m,
                     input logic cs, input logic [2:0] rs, input logic b,
                     input logic bt, input logic t, input logic [7:0] s);
    clr();
    op = o;
    {tmc, csup, rst_st, bp, btk, te} = {m, cs, rs, b, bt, t};
    @(negedge mclk_in);
    issue(1'b1, 1'b1);
    if (s == 8'h00) no_fault(6);
    else begin
      expect_fault(tfl_pkg::TRACE_FAULT_TYPE, s);
      chk("resume after trace", res, pc + 32'h4);
      hret(1'b1);
    end
  endtask

  // acc bits: 0 wr, 1 rd, 2 ram hit, 3 mmr, 4 timer, 5 tprot, 6 sfr, 7 irp
  task automatic tcase(input tfl_pkg::tfl_op_t o, input logic u,
                       input logic [7:0] acc, input logic sp,
                       input logic [7:0] off, input logic exp);
    clr();
    op = o;
    {user, irp, sfr, tprot, tmr, mmr, hit, rd, wr} = {u, acc};
    sirp = sp;
    maddr = 32'h0010_0000 + {24'h0, off};
    tmc = 8'h02;
    @(negedge mclk_in);
    issue(1'b0, !exp);
    if (exp) begin
      expect_fault(tfl_pkg::TYPE_FAULT_TYPE, tfl_pkg::TYPE_MISMATCH);
      chk("fault_addr_out", fadr, pc);
    end
    // let the one-cycle fault pulse pass before looking for more
    @(negedge mclk_in);
    no_fault(6);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    pc = 32'h0000_1000;
    clr();
    rst_in = 1'b1;
    repeat (4) @(negedge mclk_in);
    chk("fault_out in reset", flt, 1'b0);
    rst_in = 1'b0;
    repeat (2) @(negedge mclk_in);
    chk("te after reset", te_o, 1'b1);
    $display("test reset done");

    trc(tfl_pkg::TFL_OP_OTHER, 8'h02, 0, 3'h0, 0, 0, 1, 8'h02);
    trc(tfl_pkg::TFL_OP_OTHER, 8'h02, 0, 3'h0, 0, 0, 0, 8'h00);
    trc(tfl_pkg::TFL_OP_BRANCH, 8'h04, 0, 3'h0, 0, 1, 1, 8'h04);
    trc(tfl_pkg::TFL_OP_BRANCH, 8'h04, 0, 3'h0, 0, 0, 1, 8'h00);
    trc(tfl_pkg::TFL_OP_CALL, 8'h0a, 0, 3'h0, 0, 0, 1, 8'h0a);
    trc(tfl_pkg::TFL_OP_CALLS, 8'h40, 1, 3'h0, 0, 0, 1, 8'h40);
    trc(tfl_pkg::TFL_OP_RET, 8'h40, 0, 3'h2, 0, 0, 1, 8'h40);
    trc(tfl_pkg::TFL_OP_RET, 8'h50, 0, 3'h3, 0, 0, 1, 8'h50);
    trc(tfl_pkg::TFL_OP_RET, 8'h40, 0, 3'h0, 0, 0, 1, 8'h00);
    trc(tfl_pkg::TFL_OP_MARK, 8'h80, 0, 3'h0, 0, 0, 1, 8'h80);
    trc(tfl_pkg::TFL_OP_FMARK, 8'h00, 0, 3'h0, 0, 0, 1, 8'h80);
    trc(tfl_pkg::TFL_OP_OTHER, 8'h00, 0, 3'h0, 1, 0, 1, 8'h80);
    trc(tfl_pkg::TFL_OP_MARK, 8'h00, 0, 3'h0, 0, 0, 1, 8'h00);
    $display("test trace events done");

    // other fault and interrupt on a traced instruction: trace comes last
    clr();
    {tmc, ofl, intr} = {8'h02, 2'h3};
    @(negedge mclk_in);
    issue(1'b1, 1'b1);
    for (int i = 0; i < 6 && s_oth !== 1'b1; i++) @(negedge mclk_in);
    chk("service_other_out", s_oth, 1'b1);
    chk("service_intr_out held", s_int, 1'b0);
    chk("trace held back", flt, 1'b0);
    svc = 1'b1;
    @(negedge mclk_in);
    svc = 1'b0;
    for (int i = 0; i < 6 && s_int !== 1'b1; i++) @(negedge mclk_in);
    chk("service_intr_out", s_int, 1'b1);
    chk("trace held back", flt, 1'b0);
    svc = 1'b1;
    @(negedge mclk_in);
    svc = 1'b0;
    expect_fault(tfl_pkg::TRACE_FAULT_TYPE, 8'h02);
    hret(1'b1);
    $display("test ordering done");

    // prereturn alone and ahead of the return; then the return re-executes
    clr();
    op = tfl_pkg::TFL_OP_RET;
    {tmc, pre, rst_st, intr} = {8'h30, 5'h11};
    @(negedge mclk_in);
    issue(1'b0, 1'b0);
    expect_fault(tfl_pkg::TRACE_FAULT_TYPE, 8'h20);
    chk("no interrupt first", s_int, 1'b0);
    chk("resume at return", res, pc);
    hret(1'b1);
    // a pending interrupt would put the return trace behind it
    {pre, intr} = 2'h0;
    issue(1'b1, 1'b1);
    expect_fault(tfl_pkg::TRACE_FAULT_TYPE, 8'h10);
    hret(1'b1);
    $display("test prereturn done");

    // privileged classes in user mode, one allowed in supervisor mode
    for (int k = 1; k < 8; k++) begin
      tcase(tfl_pkg::tfl_op_t'(k[3:0]), 1, 8'h00, 0, 8'h00, 1);
    end
    tcase(tfl_pkg::TFL_OP_MODPC, 0, 8'h00, 0, 8'h00, 0);
    tcase(tfl_pkg::TFL_OP_OTHER, 0, 8'h85, 0, 8'h00, 1);
    tcase(tfl_pkg::TFL_OP_OTHER, 0, 8'h05, 0, 8'h00, 0);
    tcase(tfl_pkg::TFL_OP_OTHER, 0, 8'h86, 0, 8'h00, 0);
    tcase(tfl_pkg::TFL_OP_OTHER, 0, 8'h05, 1, 8'h3f, 1);
    tcase(tfl_pkg::TFL_OP_OTHER, 0, 8'h05, 1, 8'h40, 0);
    tcase(tfl_pkg::TFL_OP_OTHER, 1, 8'h05, 1, 8'h00, 1);
    tcase(tfl_pkg::TFL_OP_OTHER, 1, 8'h09, 0, 8'h00, 1);
    tcase(tfl_pkg::TFL_OP_OTHER, 0, 8'h09, 0, 8'h00, 0);
    tcase(tfl_pkg::TFL_OP_OTHER, 1, 8'h0a, 0, 8'h00, 0);
    tcase(tfl_pkg::TFL_OP_OTHER, 1, 8'h31, 0, 8'h00, 1);
    tcase(tfl_pkg::TFL_OP_OTHER, 1, 8'h11, 0, 8'h00, 0);
    tcase(tfl_pkg::TFL_OP_OTHER, 1, 8'h42, 0, 8'h00, 1);
    tcase(tfl_pkg::TFL_OP_OTHER, 1, 8'h41, 0, 8'h00, 1);
    tcase(tfl_pkg::TFL_OP_OTHER, 0, 8'h42, 0, 8'h00, 0);
    $display("test type faults done");
    close_out();
  end
endmodule
